// >>> bench/fsi_net_model.sv
`timescale 1ns/1ps
// stand-in for the node stack and can controller that feed the lamp block
module fsi_net_model (
   // clock
   input wire logic clk,
   // network state and controller status
   output logic [1:0] nmt_state,
   output logic bus_off,
   output logic fault,
   output logic err_frame_excess,
   output logic supv_event,
   // configured address
   output logic [7:0] node_address_setting
);
   // start idle with a legal, unique address
   initial begin
      nmt_state = 2'h0;
      {bus_off, fault, err_frame_excess, supv_event} = 4'h0;
      node_address_setting = 8'h05;
   end

   // change state just after an edge, like the real stack
   task automatic set_state(input logic [1:0] s);
      @(posedge clk);
      nmt_state <= s;
   endtask

   // error levels and address move together so one case lands in one edge
   // a bad address is only sent when a test asks for it on purpose
   task automatic set_err(input logic [3:0] e, input logic [7:0] a);
      @(posedge clk);
      {bus_off, fault, err_frame_excess, supv_event} <= e;
      node_address_setting <= a;
   endtask
endmodule

// >>> bench/fsi_top_tb.sv
`timescale 1ns/1ps
`include "fsi_cfg.svh"
// lamp block bench: patterns counted over whole periods, registers by tasks
module fsi_top_tb import fsi_pkg::*;;
   // short counts keep the run small; the flash and blink expectations derive from these
   localparam int FC = 4;
   localparam int PC = 10;
   logic clk;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic green_lamp;
   logic red_lamp;
   logic comm_en;
   logic irq;
   logic [1:0] nmt_state;
   logic bus_off;
   logic fault;
   logic err_frame_excess;
   logic supv_event;
   logic [7:0] node_address_setting;
   int bad_count = 0;
   int samples_checked = 0;
   logic [31:0] rv;
   int hi;
   int rs;
   // error cases: {bus_off,fault,frames,supv}, address, window, highs, rises
   logic [3:0] c_err [8] = '{4'hc, 4'h5, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
   logic [7:0] c_adr [8] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h00, 8'h80, 8'h7f, 8'h01};
   int c_win [8] = '{20, 2 * (FC + PC), 2 * (FC + PC), 2 * (3 * FC + PC), 4 * FC, 4 * FC, 20, 20};
   int c_hi [8] = '{20, 2 * FC, 2 * FC, 4 * FC, 2 * FC, 2 * FC, 0, 0};
   int c_rs [8] = '{0, 2, 2, 4, 2, 2, 0, 0};
   logic c_en [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

   // free-running 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   fsi_top #(.FLASH_CYC(FC), .PAUSE_CYC(PC)) u_fsi_top (
      .clk(clk), .rst_n(rst_n), .nmt_state(nmt_state), .bus_off(bus_off),
      .fault(fault), .err_frame_excess(err_frame_excess), .supv_event(supv_event),
      .node_address_setting(node_address_setting), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .green_lamp(green_lamp), .red_lamp(red_lamp), .comm_en(comm_en), .irq(irq)
   );

   fsi_net_model u_fsi_net_model (
      .clk(clk), .nmt_state(nmt_state), .bus_off(bus_off), .fault(fault),
      .err_frame_excess(err_frame_excess), .supv_event(supv_event),
      .node_address_setting(node_address_setting)
   );

   // single compare point; four-state equality so unknowns never match
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // one-cycle read strobe; data only stands in the following cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // count lit cycles and turn-ons; whole periods make it phase independent
   task automatic meas(input int n, input bit g, output int h, output int r);
      logic p;
      logic c;
      h = 0;
      r = 0;
      #1;
      p = g ? green_lamp : red_lamp;
      repeat (n) begin
         @(posedge clk);
         #1;
         c = g ? green_lamp : red_lamp;
         h += (c === 1'b1);
         r += (c === 1'b1 && p === 1'b0);
         p = c;
      end
   endtask

   // the one place where the run ends
   task automatic stop_test;
      $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test;
   end

   // main sequence
   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // init state and no error: both lamps dark
      #1;
      check({30'h0, green_lamp, red_lamp}, 32'h0);
      // green follows the network state
      u_fsi_net_model.set_state(`FSI_NMT_OPER);
      repeat (3) @(posedge clk);
      meas(20, 1'b1, hi, rs);
      check(32'(hi), 32'd20);
      u_fsi_net_model.set_state(`FSI_NMT_PREOP);
      repeat (3) @(posedge clk);
      meas(4 * FC, 1'b1, hi, rs);
      check(32'(hi), 32'(2 * FC));
      check(32'(rs), 32'h2);
      u_fsi_net_model.set_state(`FSI_NMT_STOPPED);
      repeat (3) @(posedge clk);
      meas(2 * (FC + PC), 1'b1, hi, rs);
      check(32'(hi), 32'(2 * FC));
      check(32'(rs), 32'h2);
      // red pattern per error mix, worst one wins; address gates the bus
      for (int i = 0; i < 8; i++) begin
         u_fsi_net_model.set_err(c_err[i], c_adr[i]);
         repeat (4) @(posedge clk);
         // look after the edge has settled, not in its own time step
         #1;
         check({31'h0, comm_en}, {31'h0, c_en[i]});
         meas(c_win[i], 1'b0, hi, rs);
         check(32'(hi), 32'(c_hi[i]));
         check(32'(rs), 32'(c_rs[i]));
      end
      // every event class has fired at least once, none enabled yet
      rd(`FSI_REG_STATUS, rv);
      check(rv, 32'h3f);
      check({31'h0, irq}, 32'h0);
      wr(`FSI_REG_IRQ_EN, 32'h1);
      @(posedge clk);
      #1;
      check({31'h0, irq}, 32'h1);
      rd(`FSI_REG_IRQ_EN, rv);
      check(rv, 32'h1);
      wr(`FSI_REG_IRQ_CLR, 32'h3f);
      @(posedge clk);
      #1;
      check({31'h0, irq}, 32'h0);
      rd(`FSI_REG_STATUS, rv);
      check(rv, 32'h0);
      // clear reads back empty and a hole in the map reads zero
      rd(`FSI_REG_IRQ_CLR, rv);
      check(rv, 32'h0);
      rd(8'h14, rv);
      check(rv, 32'h0);
      // lamp test forces the red lamp on
      wr(`FSI_REG_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      meas(10, 1'b0, hi, rs);
      check(32'(hi), 32'd10);
      wr(`FSI_REG_CTRL, 32'h0);
      // operational, clean, valid address: state word
      u_fsi_net_model.set_state(`FSI_NMT_OPER);
      repeat (4) @(posedge clk);
      rd(`FSI_REG_STATE, rv);
      check(rv, 32'h163);
      stop_test;
   end
endmodule

// >>> core/fsi_cfg.svh
`ifndef FSI_CFG_SVH
`define FSI_CFG_SVH
// system clock rate in kHz, 8 ns period
`define FSI_CLK_KHZ 125000
// lamp on/off period and pause after a flash group, in ms
`define FSI_FLASH_MS 200
`define FSI_PAUSE_MS 1000
// valid node address window
`define FSI_ADDR_MIN 8'h01
`define FSI_ADDR_MAX 8'h7f
// network state codes on nmt_state
`define FSI_NMT_INIT 2'h0
`define FSI_NMT_STOPPED 2'h1
`define FSI_NMT_PREOP 2'h2
`define FSI_NMT_OPER 2'h3
// register byte offsets
`define FSI_REG_STATUS 8'h00
`define FSI_REG_IRQ_EN 8'h04
`define FSI_REG_IRQ_CLR 8'h08
`define FSI_REG_STATE 8'h0c
`define FSI_REG_CTRL 8'h10
// event bit positions in status, enable and clear
`define FSI_EV_BUSOFF 0
`define FSI_EV_ADDR 1
`define FSI_EV_FAULT 2
`define FSI_EV_ERRFRM 3
`define FSI_EV_SUPV 4
`define FSI_EV_NMT 5
`define FSI_EV_W 6
// control bit positions
`define FSI_CTRL_TEST 0
// reset values
`define FSI_IRQ_EN_RST 6'h00
`define FSI_CTRL_RST 1'h0
`endif

// >>> core/fsi_flash_if.sv
`timescale 1ns/1ps
// one flash sequencer: restart request in, lamp drive out
interface fsi_flash_if;
   logic restart; // start the group over from its first flash
   logic lamp; // lamp drive of the pattern
   modport seq (input restart, output lamp);
   modport usr (output restart, input lamp);
endinterface

// >>> core/fsi_flash_seq.sv
`timescale 1ns/1ps
`include "fsi_cfg.svh"
// flash group generator: n flashes with gaps, then a long pause
module fsi_flash_seq import fsi_pkg::*; #(
   parameter int unsigned FLASHES = 1,
   parameter int unsigned FLASH_CYC = 25000000,
   parameter int unsigned PAUSE_CYC = 125000000
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pattern carrier
   fsi_flash_if.seq fl
);
   fsi_flash_st_t st_q; // current phase
   logic [31:0] cnt_q; // cycles spent in the phase
   logic [1:0] n_q; // flashes done in this group
   wire logic [31:0] lim_w; // last count of the phase
   wire logic last_w; // phase ends this cycle
   wire logic grp_end_w; // this flash is the last of the group

   assign lim_w = (st_q == FL_PAUSE) ? PAUSE_CYC - 32'h1 : FLASH_CYC - 32'h1;
   assign last_w = (cnt_q == lim_w);
   assign grp_end_w = (n_q == 2'(FLASHES - 1));
   // lamp decoded straight from the phase flop, no glitch source
   assign fl.lamp = (st_q == FL_ON);

   // phase sequencer; restart keeps pattern changes from showing a torn group
   always_ff @(posedge clk) begin
      if (!rst_n || fl.restart) begin
         st_q <= FL_ON;
         cnt_q <= 32'h0;
         n_q <= 2'h0;
      end else if (last_w) begin
         cnt_q <= 32'h0;
         unique case (st_q)
            FL_ON: begin
               st_q <= grp_end_w ? FL_PAUSE : FL_GAP;
               n_q <= n_q + 2'h1;
            end
            FL_GAP: st_q <= FL_ON;
            FL_PAUSE: begin
               st_q <= FL_ON;
               n_q <= 2'h0;
            end
         endcase
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end
endmodule

// >>> core/fsi_pkg.sv
package fsi_pkg;
   // red lamp pattern, ranked lowest to highest severity
   typedef enum logic [2:0] {
      RED_OFF,
      RED_DOUBLE,
      RED_SINGLE,
      RED_BLINK,
      RED_ON
   } fsi_red_t;
   // phases of a flash group
   typedef enum logic [1:0] {
      FL_ON,
      FL_GAP,
      FL_PAUSE
   } fsi_flash_st_t;
endpackage

// >>> core/fsi_top.sv
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "fsi_cfg.svh"
// Notes on behaviour
// - green steady on while operational
// - green blinks while pre-operational
// - green single flash while stopped
// - red blinks on bad parameter setting
// - red single flash on fault or errors
// - red double flash on supervision event
// - address zero blocks bus, blinks red
// - address above 127 is also invalid
module fsi_top import fsi_pkg::*; #(
   parameter int unsigned FLASH_CYC = `FSI_FLASH_MS * `FSI_CLK_KHZ,
   parameter int unsigned PAUSE_CYC = `FSI_PAUSE_MS * `FSI_CLK_KHZ
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // protocol state and can controller status
   input wire logic [1:0] nmt_state,
   input wire logic bus_off,
   input wire logic fault,
   input wire logic err_frame_excess,
   input wire logic supv_event,
   // configuration
   input wire logic [7:0] node_address_setting,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // lamps, bus permission, interrupt
   output logic green_lamp,
   output logic red_lamp,
   output logic comm_en,
   output logic irq
);
   // ---------------- address check ----------------
   wire logic addr_ok_w; // address inside the legal window
   // zero and anything above the top are both refused
   assign addr_ok_w = (node_address_setting >= `FSI_ADDR_MIN) &&
                      (node_address_setting <= `FSI_ADDR_MAX);

   logic comm_en_q; // bus participation allowed
   // registered so the bus side never sees a half-decoded address
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         comm_en_q <= 1'b0;
      end else begin
         comm_en_q <= addr_ok_w;
      end
   end
   assign comm_en = comm_en_q;

   // ---------------- blink timebase ----------------
   logic [31:0] ph_cnt_q; // cycles in the current blink phase
   logic blink_q; // steady blink, equal on and off
   wire logic ph_last_w; // blink phase ends

   assign ph_last_w = (ph_cnt_q == FLASH_CYC - 32'h1);

   // free-running blink; shared by both lamps so they blink in step
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ph_cnt_q <= 32'h0;
         blink_q <= 1'b1;
      end else if (ph_last_w) begin
         ph_cnt_q <= 32'h0;
         blink_q <= ~blink_q;
      end else begin
         ph_cnt_q <= ph_cnt_q + 32'h1;
      end
   end

   // ---------------- red pattern selection ----------------
   fsi_red_t red_sel_d; // most severe pattern now
   fsi_red_t red_sel_q; // registered selection
   wire logic err_single_w; // fault or too many error frames

   assign err_single_w = fault | err_frame_excess;

   // priority order, bus-off first, supervision last
   always_comb begin
      if (bus_off) begin
         red_sel_d = RED_ON;
      end else if (!addr_ok_w) begin
         red_sel_d = RED_BLINK;
      end else if (err_single_w) begin
         red_sel_d = RED_SINGLE;
      end else if (supv_event) begin
         red_sel_d = RED_DOUBLE;
      end else begin
         red_sel_d = RED_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         red_sel_q <= RED_OFF;
      end else begin
         red_sel_q <= red_sel_d;
      end
   end

   // ---------------- flash sequencers ----------------
   fsi_flash_if grn_fl(); // green single flash
   fsi_flash_if red_fl1(); // red single flash
   fsi_flash_if red_fl2(); // red double flash
   logic [1:0] nmt_prev_q; // last network state, for entry detect

   // restart each group on entry so the first flash is a full one
   assign grn_fl.restart = (nmt_state == `FSI_NMT_STOPPED) &&
                           (nmt_prev_q != `FSI_NMT_STOPPED);
   assign red_fl1.restart = (red_sel_d == RED_SINGLE) && (red_sel_q != RED_SINGLE);
   assign red_fl2.restart = (red_sel_d == RED_DOUBLE) && (red_sel_q != RED_DOUBLE);

   fsi_flash_seq #(
      .FLASHES(1),
      .FLASH_CYC(FLASH_CYC),
      .PAUSE_CYC(PAUSE_CYC)
   ) u_grn_single (
      .clk(clk),
      .rst_n(rst_n),
      .fl(grn_fl.seq)
   );

   fsi_flash_seq #(
      .FLASHES(1),
      .FLASH_CYC(FLASH_CYC),
      .PAUSE_CYC(PAUSE_CYC)
   ) u_red_single (
      .clk(clk),
      .rst_n(rst_n),
      .fl(red_fl1.seq)
   );

   fsi_flash_seq #(
      .FLASHES(2),
      .FLASH_CYC(FLASH_CYC),
      .PAUSE_CYC(PAUSE_CYC)
   ) u_red_double (
      .clk(clk),
      .rst_n(rst_n),
      .fl(red_fl2.seq)
   );

   // ---------------- lamp drive ----------------
   logic ctrl_test_q; // lamp test, both lamps forced on
   logic green_d; // green drive before the test override
   logic red_d; // red drive before the test override
   logic green_q; // registered green lamp
   logic red_q; // registered red lamp

   // green follows the network state; init shows dark
   always_comb begin
      unique case (nmt_state)
         `FSI_NMT_OPER: green_d = 1'b1;
         `FSI_NMT_PREOP: green_d = blink_q;
         `FSI_NMT_STOPPED: green_d = grn_fl.lamp;
         default: green_d = 1'b0;
      endcase
   end

   // red follows the registered selection
   always_comb begin
      unique case (red_sel_q)
         RED_ON: red_d = 1'b1;
         RED_BLINK: red_d = blink_q;
         RED_SINGLE: red_d = red_fl1.lamp;
         RED_DOUBLE: red_d = red_fl2.lamp;
         default: red_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         green_q <= 1'b0;
         red_q <= 1'b0;
      end else begin
         green_q <= green_d | ctrl_test_q;
         red_q <= red_d | ctrl_test_q;
      end
   end
   assign green_lamp = green_q;
   assign red_lamp = red_q;

   // ---------------- events ----------------
   logic [4:0] lvl_prev_q; // previous error levels
   wire logic [4:0] lvl_w; // current error levels
   wire logic [`FSI_EV_W-1:0] ev_w; // one-cycle events

   assign lvl_w = {supv_event, err_frame_excess, fault, ~addr_ok_w, bus_off};
   // rising edges of each condition plus any network state change
   assign ev_w = {nmt_state != nmt_prev_q, lvl_w & ~lvl_prev_q};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lvl_prev_q <= 5'h00;
         nmt_prev_q <= `FSI_NMT_INIT;
      end else begin
         lvl_prev_q <= lvl_w;
         nmt_prev_q <= nmt_state;
      end
   end

   // ---------------- register port ----------------
   wire logic wr_en_w; // write to enable register
   wire logic wr_clr_w; // write to clear register
   wire logic wr_ctrl_w; // write to control register
   wire logic [`FSI_EV_W-1:0] clr_w; // bits being cleared
   logic [`FSI_EV_W-1:0] status_q; // sticky event bits
   logic [`FSI_EV_W-1:0] irq_en_q; // interrupt enables
   logic [31:0] rd_mux_w; // read data before the register
   logic [31:0] rdata_q; // read data, valid one cycle after the strobe
   logic irq_q; // registered interrupt

   assign wr_en_w = reg_wr && (reg_addr == `FSI_REG_IRQ_EN);
   assign wr_clr_w = reg_wr && (reg_addr == `FSI_REG_IRQ_CLR);
   assign wr_ctrl_w = reg_wr && (reg_addr == `FSI_REG_CTRL);
   assign clr_w = wr_clr_w ? reg_wdata[`FSI_EV_W-1:0] : '0;

   // read select; clear register and unmapped offsets read zero
   assign rd_mux_w =
      (reg_addr == `FSI_REG_STATUS) ? {26'h0, status_q} :
      (reg_addr == `FSI_REG_IRQ_EN) ? {26'h0, irq_en_q} :
      (reg_addr == `FSI_REG_STATE) ? {23'h0, comm_en_q, red_q, green_q,
                                      addr_ok_w, red_sel_q, nmt_state} :
      (reg_addr == `FSI_REG_CTRL) ? {31'h0, ctrl_test_q} : 32'h0;

   // writable registers; a new event beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_q <= '0;
         irq_en_q <= `FSI_IRQ_EN_RST;
         ctrl_test_q <= `FSI_CTRL_RST;
      end else begin
         status_q <= (status_q & ~clr_w) | ev_w;
         if (wr_en_w) begin
            irq_en_q <= reg_wdata[`FSI_EV_W-1:0];
         end
         if (wr_ctrl_w) begin
            ctrl_test_q <= reg_wdata[`FSI_CTRL_TEST];
         end
      end
   end

   // read data only in the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0;
         irq_q <= 1'b0;
      end else begin
         rdata_q <= reg_rd ? rd_mux_w : 32'h0;
         irq_q <= |((status_q & ~clr_w | ev_w) & irq_en_q);
      end
   end
   assign reg_rdata = rdata_q;
   assign irq = irq_q;

   // ---------------- assertions ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_no_test;
      !ctrl_test_q;
   endsequence
   sequence s_busoff2;
      (bus_off && !ctrl_test_q) [*2];
   endsequence
   sequence s_clean2;
      (!bus_off && addr_ok_w && !err_single_w && !supv_event && !ctrl_test_q) [*2];
   endsequence

   AST_GREEN_OPER: assert property (
      (nmt_state == `FSI_NMT_OPER) ##0 s_no_test |=> green_lamp)
      else $error("green lamp dark while operational");
   AST_GREEN_PREOP: assert property (
      (nmt_state == `FSI_NMT_PREOP) ##0 s_no_test |=> green_lamp == $past(blink_q))
      else $error("green lamp not following blink");
   AST_GREEN_STOP: assert property (
      (nmt_state == `FSI_NMT_STOPPED && !ctrl_test_q) |=> green_lamp == $past(grn_fl.lamp))
      else $error("green lamp not single flashing when stopped");
   AST_RED_BUSOFF: assert property (
      s_busoff2 |=> red_lamp)
      else $error("red lamp dark during bus-off");
   AST_RED_CLEAN: assert property (
      s_clean2 |=> !red_lamp)
      else $error("red lamp lit with no error");
   AST_ADDR_ZERO: assert property (
      (node_address_setting == 8'h00) |=> !comm_en)
      else $error("bus allowed with address zero");
   AST_ADDR_HIGH: assert property (
      (node_address_setting > `FSI_ADDR_MAX && !bus_off) |=> red_sel_q == RED_BLINK)
      else $error("high address not flagged");
   AST_RED_SINGLE: assert property (
      (addr_ok_w && !bus_off && err_single_w) |=> red_sel_q == RED_SINGLE)
      else $error("fault not shown as single flash");
   AST_RED_DOUBLE: assert property (
      (addr_ok_w && !bus_off && !err_single_w && supv_event) |=> red_sel_q == RED_DOUBLE)
      else $error("supervision event not shown as double flash");
   AST_RED_PRIO: assert property (
      (bus_off && (fault || supv_event || !addr_ok_w)) |=> red_sel_q == RED_ON)
      else $error("bus-off not ranked highest");
   AST_BLINK_RATE: assert property (
      $changed(blink_q) |-> $past(ph_last_w))
      else $error("blink toggled off the phase boundary");
   AST_PH_RANGE: assert property (
      ph_cnt_q <= FLASH_CYC - 32'h1)
      else $error("blink phase counter overran");
endmodule
